// ==== hw/ctx_regfile_params.svh ====
`ifndef CTX_REGFILE_PARAMS_SVH
`define CTX_REGFILE_PARAMS_SVH

// ==========================================================
// context and register geometry
`define NUM_CTX        5
`define CTX_W          3
`define MASTER_CTX     3'h0
`define WORD_W         32
`define SW_W           16
`define FC_W           3
`define NUM_DATA       8
`define NUM_PTR        7
`define EXT_ADDR_W     31
`define EXT_DATA_W     16
`define ENDIAN_BIT     31

// ==========================================================
// context state word fields
`define SW_SUPER_BIT   13
`define SW_CC_MSB      7
`define SW_RESET       16'h2700

// ==========================================================
// axi4-lite map: word index = ctx*32 + reg; byte addr = index*4
`define ADDR_W         12
`define REG_DATA0      5'h00
`define REG_PTR0       5'h08
`define REG_USP        5'h0f
`define REG_SSP        5'h10
`define REG_PC         5'h11
`define REG_SW         5'h12
`define REG_VTB        5'h13
`define REG_SFC        5'h14
`define REG_DFC        5'h15
`define REG_LAST       5'h15

`endif

// ==== hw/ctx_regfile_pkg.sv ====
package ctx_regfile_pkg;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_WORD = 2'b01,
        SZ_LONG = 2'b10
    } op_size_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_RESP = 2'b01
    } rd_state_t;

endpackage

// ==== hw/multi_context_register_file.sv ====
`timescale 1ns/10ps
`include "ctx_regfile_params.svh"

// Notes on behaviour
// RULE1: five contexts each own a full register set; one execution unit serves all.
// RULE2: internal address and data paths are 32 bits wide.
// RULE3: address bit 31 selects endian mode; space limited to two gigabytes.
// RULE4: external address is 31 bits, external data 16 bits.
// RULE5: a context's registers accept writes only from owner or master context.
// RULE6: each set: 8 data, 7 pointer, 2 stacks, pc, 16-bit state, base, two 3-bit codes.
// RULE7: stack pointer reference picks supervisor stack when supervisor bit set.
// RULE8: memory is byte addressed; multi-byte values stored most significant byte first.
// RULE9: byte or word writes to data registers change only the low portion.
// RULE10: 64-bit result may land in any two data registers, any order.
// RULE11: signed values are two's complement; bcd operand is the low byte.
// RULE12: pointer registers are never byte operands.
// RULE13: word source from pointer register is sign-extended to 32 bits.
// RULE14: any write to a pointer register updates all 32 bits.
// RULE15: unaligned word and long accesses complete without address fault.
// RULE16: privileged operations run only in supervisor mode.
// RULE17: user mode writes only the low 8 state bits; supervisor writes all.
// RULE18: each context keeps its own state word copy.
// RULE19: access-controlled fields written only by master context in supervisor mode.
// RULE20: simultaneous owner and master writes to one register: master wins.
module multi_context_register_file (
    // clock and reset
    input  wire  logic                        ref_clk,
    input  wire  logic                        rst_n,
    // owning context write/read port (execution unit)
    input  wire  logic [`CTX_W-1:0]           own_ctx,
    input  wire  logic                        own_wr,
    input  wire  logic [4:0]                  own_reg,
    input  wire  ctx_regfile_pkg::op_size_t   own_size,
    input  wire  logic [`WORD_W-1:0]          own_wdata,
    input  wire  logic                        own_wr_hi,
    input  wire  logic [4:0]                  own_reg_hi,
    input  wire  logic [`WORD_W-1:0]          own_wdata_hi,
    input  wire  logic                        own_rd,
    input  wire  logic [4:0]                  own_rd_reg,
    input  wire  ctx_regfile_pkg::op_size_t   own_rd_size,
    input  wire  logic                        priv_req,
    // master context write port (execution unit)
    input  wire  logic [`CTX_W-1:0]           mst_src_ctx,
    input  wire  logic [`CTX_W-1:0]           mst_tgt_ctx,
    input  wire  logic                        mst_wr,
    input  wire  logic [4:0]                  mst_reg,
    input  wire  logic [`WORD_W-1:0]          mst_wdata,
    // memory address mapping
    input  wire  logic [`WORD_W-1:0]          mem_addr,
    input  wire  ctx_regfile_pkg::op_size_t   mem_size,
    // read results
    output logic [`WORD_W-1:0]                own_rdata,
    output logic                              own_rd_fault,
    output logic                              priv_ok,
    output logic [`WORD_W-1:0]                stack_ptr,
    output logic                              sel_super,
    output logic [`EXT_ADDR_W-1:0]            ext_addr,
    output logic                              ext_little,
    output logic [3:0]                        mem_lane_order,
    output logic                              mem_addr_fault,
    // axi4-lite slave
    input  wire  logic [`ADDR_W-1:0]          s_axi_awaddr,
    input  wire  logic                        s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire  logic [31:0]                 s_axi_wdata,
    input  wire  logic [3:0]                  s_axi_wstrb,
    input  wire  logic                        s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire  logic                        s_axi_bready,
    input  wire  logic [`ADDR_W-1:0]          s_axi_araddr,
    input  wire  logic                        s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire  logic                        s_axi_rready
);

    // ==========================================================
    // storage, one set per context
    logic [`WORD_W-1:0] data_r  [`NUM_CTX][`NUM_DATA];  // see RULE1 see RULE2 see RULE6
    logic [`WORD_W-1:0] ptr_r   [`NUM_CTX][`NUM_PTR];
    logic [`WORD_W-1:0] usp_r   [`NUM_CTX];
    logic [`WORD_W-1:0] ssp_r   [`NUM_CTX];
    logic [`WORD_W-1:0] pc_r    [`NUM_CTX];
    logic [`SW_W-1:0]   sw_r    [`NUM_CTX];             // see RULE18
    logic [`WORD_W-1:0] vtb_r   [`NUM_CTX];
    logic [`FC_W-1:0]   sfc_r   [`NUM_CTX];
    logic [`FC_W-1:0]   dfc_r   [`NUM_CTX];

    // ==========================================================
    // helpers
    function automatic logic [`WORD_W-1:0] reg_read(input logic [4:0] r, input logic [`CTX_W-1:0] c);
        logic [`WORD_W-1:0] v;
        v = '0;
        if (r < `REG_PTR0)
            v = data_r[c][r[2:0]];
        else if (r < `REG_USP)
            v = ptr_r[c][3'(r - `REG_PTR0)];
        else if (r == `REG_USP)
            v = usp_r[c];
        else if (r == `REG_SSP)
            v = ssp_r[c];
        else if (r == `REG_PC)
            v = pc_r[c];
        else if (r == `REG_SW)
            v = {16'h0000, sw_r[c]};
        else if (r == `REG_VTB)
            v = vtb_r[c];
        else if (r == `REG_SFC)
            v = {29'h0, sfc_r[c]};
        else if (r == `REG_DFC)
            v = {29'h0, dfc_r[c]};
        return v;
    endfunction

    function automatic logic is_ptr(input logic [4:0] r);
        return (r >= `REG_PTR0) && (r <= `REG_SSP);
    endfunction

    // ==========================================================
    // write arbitration
    wire own_valid_ctx = own_ctx < `CTX_W'(`NUM_CTX);
    wire own_is_master = own_ctx == `MASTER_CTX;
    wire mst_ok        = mst_wr && (mst_src_ctx == `MASTER_CTX)   // see RULE5
                         && (mst_tgt_ctx < `CTX_W'(`NUM_CTX));
    wire mst_super     = sw_r[`MASTER_CTX][`SW_SUPER_BIT];
    wire own_super     = own_valid_ctx && sw_r[own_ctx][`SW_SUPER_BIT];
    // master loses nothing: same target and register means the owner write is dropped
    wire clash         = mst_ok && own_wr && (mst_tgt_ctx == own_ctx) && (mst_reg == own_reg); // see RULE20
    wire own_byte_ptr  = is_ptr(own_reg) && (own_size == ctx_regfile_pkg::SZ_BYTE);
    wire own_go        = own_wr && own_valid_ctx && !clash && !own_byte_ptr; // see RULE12
    wire own_hi_go     = own_wr_hi && own_valid_ctx && (own_reg_hi < `REG_PTR0)
                         && !(mst_ok && mst_tgt_ctx == own_ctx && mst_reg == own_reg_hi);  // see RULE10

    // access-controlled fields: function codes and vector base, master in supervisor only
    wire mst_ac_ok     = mst_super;                                        // see RULE19
    wire own_ac_ok     = own_is_master && own_super;

    // axi write (treated as a master-context access)
    logic aw_have_r, w_have_r;
    logic [`ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    wire [4:0]  axw_reg   = aw_addr_r[6:2];
    wire [`CTX_W-1:0] axw_ctx = `CTX_W'(aw_addr_r[`ADDR_W-1:7]);
    wire axw_hit   = (aw_addr_r[`ADDR_W-1:7] < `NUM_CTX) && (axw_reg <= `REG_LAST);
    wire axw_fire  = aw_have_r && w_have_r && !s_axi_bvalid;
    wire axw_go    = axw_fire && axw_hit && !mst_ok && !own_wr && !own_wr_hi;
    wire [31:0] axw_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

    // ==========================================================
    // per-context update
    genvar gc, gr;
    generate
        for (gc = 0; gc < `NUM_CTX; gc++) begin : g_ctx
            wire m_sel = mst_ok && (mst_tgt_ctx == gc);
            wire o_sel = own_go && (own_ctx == gc);
            wire h_sel = own_hi_go && (own_ctx == gc);
            wire a_sel = axw_go && (axw_ctx == gc);
            for (gr = 0; gr <= `REG_LAST; gr++) begin : g_reg
                wire m_hit = m_sel && (mst_reg == gr);
                wire o_hit = o_sel && (own_reg == gr);
                wire h_hit = h_sel && (own_reg_hi == gr);
                wire a_hit = a_sel && (axw_reg == gr);
                wire [31:0] cur = reg_read(5'(gr), `CTX_W'(gc));
                logic [31:0] o_val;
                always_comb begin
                    o_val = own_wdata;
                    if (gr < `REG_PTR0) begin
                        if (own_size == ctx_regfile_pkg::SZ_BYTE)
                            o_val = {cur[31:8], own_wdata[7:0]};   // see RULE9
                        else if (own_size == ctx_regfile_pkg::SZ_WORD)
                            o_val = {cur[31:16], own_wdata[15:0]};
                    end else if (gr <= `REG_SSP) begin
                        if (own_size == ctx_regfile_pkg::SZ_WORD)
                            o_val = {{16{own_wdata[15]}}, own_wdata[15:0]}; // see RULE14
                    end else if (gr == `REG_SW) begin
                        if (!own_super)
                            o_val = {cur[31:8], own_wdata[`SW_CC_MSB:0]}; // see RULE17
                    end
                end
                wire ac    = (gr == `REG_VTB) || (gr == `REG_SFC) || (gr == `REG_DFC);
                wire m_en  = m_hit && (!ac || mst_ac_ok);
                wire o_en  = o_hit && (!ac || own_ac_ok);
                wire a_en  = a_hit && (!ac || mst_ac_ok);
                wire we    = m_en || o_en || h_hit || a_en;
                wire [31:0] nv = m_en ? mst_wdata :                    // see RULE20
                                 o_en ? o_val :
                                 h_hit ? own_wdata_hi :
                                 ((cur & ~axw_mask) | (w_data_r & axw_mask));
                always_ff @(posedge ref_clk or negedge rst_n) begin
                    if (!rst_n) begin
                        if (gr < `REG_PTR0)       data_r[gc][gr] <= '0;
                        else if (gr < `REG_USP)   ptr_r[gc][gr - `REG_PTR0] <= '0;
                        else if (gr == `REG_USP)  usp_r[gc] <= '0;
                        else if (gr == `REG_SSP)  ssp_r[gc] <= '0;
                        else if (gr == `REG_PC)   pc_r[gc] <= '0;
                        else if (gr == `REG_SW)   sw_r[gc] <= `SW_RESET;
                        else if (gr == `REG_VTB)  vtb_r[gc] <= '0;
                        else if (gr == `REG_SFC)  sfc_r[gc] <= '0;
                        else                      dfc_r[gc] <= '0;
                    end else if (we) begin
                        if (gr < `REG_PTR0)       data_r[gc][gr] <= nv;
                        else if (gr < `REG_USP)   ptr_r[gc][gr - `REG_PTR0] <= nv;
                        else if (gr == `REG_USP)  usp_r[gc] <= nv;
                        else if (gr == `REG_SSP)  ssp_r[gc] <= nv;
                        else if (gr == `REG_PC)   pc_r[gc] <= nv;
                        else if (gr == `REG_SW)   sw_r[gc] <= nv[15:0];
                        else if (gr == `REG_VTB)  vtb_r[gc] <= nv;
                        else if (gr == `REG_SFC)  sfc_r[gc] <= nv[2:0];
                        else                      dfc_r[gc] <= nv[2:0];
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // owning-context read path
    wire [31:0] rd_raw   = own_valid_ctx ? reg_read(own_rd_reg, own_ctx) : '0;
    wire        rd_ptr   = is_ptr(own_rd_reg);
    wire        rd_bad   = own_rd && rd_ptr && (own_rd_size == ctx_regfile_pkg::SZ_BYTE); // see RULE12
    wire [31:0] rd_val   = rd_ptr && (own_rd_size == ctx_regfile_pkg::SZ_WORD) ?
                           {{16{rd_raw[15]}}, rd_raw[15:0]} :                 // see RULE13
                           (own_rd_size == ctx_regfile_pkg::SZ_BYTE) ? {24'h0, rd_raw[7:0]} : // see RULE11
                           (own_rd_size == ctx_regfile_pkg::SZ_WORD) ? {16'h0, rd_raw[15:0]} : rd_raw;
    // stack references follow the supervisor bit of the owner
    wire [31:0] sp_val   = own_valid_ctx ? (own_super ? ssp_r[own_ctx] : usp_r[own_ctx]) : '0; // see RULE7

    // ==========================================================
    // memory address mapping; never faults on odd addresses
    wire [3:0] lanes     = (mem_size == ctx_regfile_pkg::SZ_LONG) ? 4'h0 :   // see RULE8
                           (mem_size == ctx_regfile_pkg::SZ_WORD) ? 4'h2 : 4'h3;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            own_rdata      <= '0;
            own_rd_fault   <= 1'b0;
            priv_ok        <= 1'b0;
            stack_ptr      <= '0;
            sel_super      <= 1'b0;
            ext_addr       <= '0;
            ext_little     <= 1'b0;
            mem_lane_order <= '0;
            mem_addr_fault <= 1'b0;
        end else begin
            own_rdata      <= rd_bad ? '0 : rd_val;
            own_rd_fault   <= rd_bad;
            priv_ok        <= priv_req && own_super;               // see RULE16
            stack_ptr      <= sp_val;
            sel_super      <= own_super;
            ext_addr       <= mem_addr[`EXT_ADDR_W-1:0];           // see RULE3 see RULE4
            ext_little     <= mem_addr[`ENDIAN_BIT];
            mem_lane_order <= lanes;
            mem_addr_fault <= 1'b0;                                // see RULE15
        end
    end

    // ==========================================================
    // axi4-lite slave: one write, one read at a time
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            aw_addr_r    <= '0;
            w_data_r     <= '0;
            w_strb_r     <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else begin
            s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            // hold the write while the execution unit is writing this cycle
            if (axw_fire && (!axw_hit || axw_go)) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= axw_hit ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ctx_regfile_pkg::rd_state_t rd_st_r;
    wire [4:0]        axr_reg = s_axi_araddr[6:2];
    wire              axr_hit = (s_axi_araddr[`ADDR_W-1:7] < `NUM_CTX) && (axr_reg <= `REG_LAST);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_st_r       <= ctx_regfile_pkg::RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= 2'b00;
        end else begin
            case (rd_st_r)
                ctx_regfile_pkg::RD_IDLE: begin
                    s_axi_arready <= !s_axi_arready;
                    if (s_axi_arvalid && s_axi_arready) begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid  <= 1'b1;
                        s_axi_rdata   <= axr_hit ? reg_read(axr_reg, `CTX_W'(s_axi_araddr[`ADDR_W-1:7])) : '0;
                        s_axi_rresp   <= axr_hit ? 2'b00 : 2'b10;
                        rd_st_r       <= ctx_regfile_pkg::RD_RESP;
                    end
                end
                ctx_regfile_pkg::RD_RESP: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        rd_st_r      <= ctx_regfile_pkg::RD_IDLE;
                    end
                end
                default: rd_st_r <= ctx_regfile_pkg::RD_IDLE;
            endcase
        end
    end

    // ==========================================================
    // checks
    property p_user_cc_only;
        @(posedge ref_clk) disable iff (!rst_n)
        (own_wr && own_reg == `REG_SW && !own_super && !mst_ok && !axw_go)
            |=> sw_r[$past(own_ctx)][15:8] == $past(sw_r[own_ctx][15:8]);
    endproperty
    a_user_cc_only: assert property (p_user_cc_only) else $error("user write changed upper state bits"); // see RULE17

    property p_priv;
        @(posedge ref_clk) disable iff (!rst_n)
        priv_ok |-> $past(priv_req) && $past(own_super);
    endproperty
    a_priv: assert property (p_priv) else $error("privilege granted outside supervisor"); // see RULE16

    property p_sext;
        @(posedge ref_clk) disable iff (!rst_n)
        (own_rd && is_ptr(own_rd_reg) && own_rd_size == ctx_regfile_pkg::SZ_WORD)
            |=> own_rdata[31:16] == {16{own_rdata[15]}};
    endproperty
    a_sext: assert property (p_sext) else $error("pointer word read not sign extended"); // see RULE13

    property p_no_byte_ptr;
        @(posedge ref_clk) disable iff (!rst_n)
        rd_bad |=> own_rd_fault && own_rdata == '0;
    endproperty
    a_no_byte_ptr: assert property (p_no_byte_ptr) else $error("byte pointer read not refused"); // see RULE12

    property p_stack_sel;
        @(posedge ref_clk) disable iff (!rst_n)
        sel_super |-> stack_ptr == $past(ssp_r[own_ctx]);
    endproperty
    a_stack_sel: assert property (p_stack_sel) else $error("stack pointer select wrong"); // see RULE7

    property p_endian;
        @(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> ext_little == $past(mem_addr[31]) && ext_addr == $past(mem_addr[30:0]);
    endproperty
    a_endian: assert property (p_endian) else $error("endian bit or address wrong"); // see RULE3

    property p_no_align_fault;
        @(posedge ref_clk) disable iff (!rst_n)
        mem_addr[0] ##1 1'b1 |-> !mem_addr_fault;
    endproperty
    a_no_align_fault: assert property (p_no_align_fault) else $error("odd address faulted"); // see RULE15

    property p_master_wins;
        @(posedge ref_clk) disable iff (!rst_n)
        (clash && mst_reg == `REG_PC && mst_tgt_ctx < 3'h5) |=> pc_r[$past(mst_tgt_ctx)] == $past(mst_wdata);
    endproperty
    a_master_wins: assert property (p_master_wins) else $error("master write lost on clash"); // see RULE20

endmodule

// ==== tb/exu_model.sv ====
`timescale 1ns/10ps
// ==========================
// shared execution unit stand-in
module exu_model (
    // clock
    input  wire  logic                ref_clk,
    // owner request
    output logic [2:0]                own_ctx,
    output logic                      own_wr,
    output logic                      own_rd,
    output logic                      priv_req,
    output logic [4:0]                own_reg,
    output ctx_regfile_pkg::op_size_t own_size,
    output logic [31:0]               own_wdata,
    // master request
    output logic                      mst_wr,
    output logic [2:0]                mst_src_ctx,
    output logic [31:0]               mst_wdata
);
    initial begin
        {own_wr, own_rd, priv_req, mst_wr} = 4'h0;
        {own_ctx, mst_src_ctx, own_reg} = 11'h0;
        own_size = ctx_regfile_pkg::SZ_LONG;
        {own_wdata, mst_wdata} = 64'h0;
    end
    // one unit serves all contexts, each op drives one cycle then idles one cycle
    task automatic op(input logic [2:0] c, input logic [4:0] r, input ctx_regfile_pkg::op_size_t s,
                      input logic [31:0] v, input logic ow, input logic mw, input logic [2:0] ms,
                      input logic [31:0] mv, input logic rq);
        @(posedge ref_clk);
        own_ctx <= c;
        own_reg <= r;
        own_size <= s;
        own_wdata <= v;
        mst_src_ctx <= ms;
        mst_wdata <= mv;
        {own_wr, mst_wr, own_rd, priv_req} <= {ow, mw, rq, rq};
        @(posedge ref_clk);
        {own_wr, mst_wr, own_rd, priv_req} <= 4'h0;
        own_wdata <= ~v;
        mst_wdata <= ~mv;
    endtask
endmodule

// ==== tb/multi_context_register_file_test.sv ====
`timescale 1ns/10ps
// ==========================
// bench: register file beside execution unit stand-in
module multi_context_register_file_test;
    localparam ctx_regfile_pkg::op_size_t B = ctx_regfile_pkg::SZ_BYTE;
    localparam ctx_regfile_pkg::op_size_t W = ctx_regfile_pkg::SZ_WORD;
    localparam ctx_regfile_pkg::op_size_t L = ctx_regfile_pkg::SZ_LONG;
    logic ref_clk, rst_n, own_wr, own_rd, priv_req, mst_wr, own_rd_fault, priv_ok, sel_super, ext_little;
    logic mem_addr_fault, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] own_ctx, mst_src_ctx;
    logic [3:0] mem_lane_order;
    logic [4:0] own_reg;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [30:0] ext_addr;
    logic [31:0] own_wdata, mst_wdata, mem_addr, own_rdata, stack_ptr, s_axi_wdata, s_axi_rdata, d;
    ctx_regfile_pkg::op_size_t own_size;
    int err_total, tests_run;
    multi_context_register_file dut_u (.*, .own_rd_reg(own_reg), .own_rd_size(own_size), .mst_tgt_ctx(own_ctx),
        .mst_reg(own_reg), .mem_size(own_size), .own_wr_hi(mst_wr), .own_reg_hi(5'h05), .own_wdata_hi(mst_wdata),
        .s_axi_wstrb(4'hf));
    exu_model exu_u (.*);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic ow(input logic [2:0] c, input logic [4:0] r, input ctx_regfile_pkg::op_size_t s,
                      input logic [31:0] v);
        exu_u.op(c, r, s, v, 1'b1, 1'b0, 3'h7, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [2:0] c, input logic [4:0] r, input ctx_regfile_pkg::op_size_t s);
        exu_u.op(c, r, s, 32'h0, 1'b0, 1'b0, 3'h7, 32'h0, 1'b1);
        #1;
    endtask
    // bounded waits; after 50 cycles a hang ends the run with the tally as it stands
    task automatic axw(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        @(posedge ref_clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        chk("bresp", s_axi_bresp, er);
        if (n == 50) tally_and_finish;
    endtask
    task automatic axr(input logic [11:0] a, input logic [1:0] er);
        int n;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        chk("rresp", s_axi_rresp, er);
        if (n == 50) tally_and_finish;
    endtask
    task automatic t_data;
        ow(3'h1, 5'h02, L, 32'h12345678);
        ow(3'h1, 5'h02, W, 32'h0000cdef);
        ow(3'h1, 5'h02, B, 32'hffffff11);
        rd(3'h1, 5'h02, L);
        chk("data low part", own_rdata, 32'h1234cd11);
        rd(3'h2, 5'h02, L);
        chk("other context", own_rdata, 32'h0);
        ow(3'h1, 5'h08, W, 32'h00008001);
        rd(3'h1, 5'h08, L);
        chk("pointer whole", own_rdata, 32'hffff8001);
        ow(3'h1, 5'h09, L, 32'h12348765);
        rd(3'h1, 5'h09, W);
        chk("pointer word", own_rdata, 32'hffff8765);
        rd(3'h1, 5'h09, B);
        chk("pointer byte", own_rd_fault, 32'h1);
        $display("t_data done");
    endtask
    task automatic t_state;
        ow(3'h1, 5'h10, L, 32'h4000);
        ow(3'h1, 5'h0f, L, 32'h3000);
        rd(3'h1, 5'h00, L);
        chk("super stack", stack_ptr, 32'h4000);
        chk("priv super", priv_ok, 32'h1);
        ow(3'h1, 5'h12, W, 32'h0);
        ow(3'h1, 5'h12, W, 32'hffff);
        rd(3'h1, 5'h12, L);
        chk("user state", own_rdata, 32'h00ff);
        chk("user stack", stack_ptr, 32'h3000);
        chk("priv user", priv_ok, 32'h0);
        rd(3'h2, 5'h12, L);
        chk("own state copy", own_rdata, 32'h2700);
        $display("t_state done");
    endtask
    task automatic t_master;
        exu_u.op(3'h1, 5'h03, L, 32'haaaaaaaa, 1'b1, 1'b1, 3'h0, 32'h55555555, 1'b0);
        exu_u.op(3'h1, 5'h03, L, 32'h0, 1'b0, 1'b1, 3'h2, 32'h11111111, 1'b0);
        rd(3'h1, 5'h03, L);
        chk("master wins", own_rdata, 32'h55555555);
        rd(3'h1, 5'h05, L);
        chk("quad pair", own_rdata, 32'h11111111);
        ow(3'h1, 5'h13, L, 32'h100);
        rd(3'h1, 5'h13, L);
        chk("base by owner", own_rdata, 32'h0);
        exu_u.op(3'h1, 5'h13, L, 32'h0, 1'b0, 1'b1, 3'h0, 32'h200, 1'b0);
        rd(3'h1, 5'h13, L);
        chk("base by master", own_rdata, 32'h200);
        mem_addr <= 32'h80000003;
        @(posedge ref_clk);
        #1;
        chk("ext addr", ext_addr, 32'h3);
        chk("endian bit", ext_little, 32'h1);
        chk("odd long", mem_addr_fault, 32'h0);
        chk("lane order", mem_lane_order, 32'h0);
        $display("t_master done");
    endtask
    task automatic t_bus;
        axw(12'h08c, 32'hdeadbeef, 2'b00);
        rd(3'h1, 5'h03, L);
        chk("bus write", own_rdata, 32'hdeadbeef);
        axr(12'h08c, 2'b00);
        chk("bus read", d, 32'hdeadbeef);
        axr(12'h058, 2'b10);
        chk("unmapped read", d, 32'h0);
        axw(12'h280, 32'h1, 2'b10);
        $display("t_bus done");
    endtask
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, mem_addr} = 88'h0;
        err_total = 0;
        tests_run = 0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_data;
        t_state;
        t_master;
        t_bus;
        tally_and_finish;
    end
endmodule
